// >>> core/adcc_map.svh
// Register map, field positions, reset values and divider counts
// Assumes: included by bare name from the converter control files
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Register addresses on the byte-wide register port
`define ADCC_ADDR_CTRL 8'h1F
`define ADCC_ADDR_PCFG 8'h9F
`define ADCC_ADDR_RESH 8'h1E
`define ADCC_ADDR_RESL 8'h9E
`define ADCC_ADDR_ISTAT 8'h20
`define ADCC_ADDR_IMASK 8'h21

// Conversion control fields
`define ADCC_CS_HI 7
`define ADCC_CS_LO 6
`define ADCC_CH_HI 5
`define ADCC_CH_LO 3
`define ADCC_GO 2
`define ADCC_ON 0

// Port configuration fields
`define ADCC_JUST 7
`define ADCC_PF_HI 3
`define ADCC_PF_LO 0

// Interrupt status and mask bit
`define ADCC_DONE_BIT 0

// Reset values
`define ADCC_CTRL_RST 8'h00
`define ADCC_PCFG_RST 8'h00
`define ADCC_IRQ_RST 8'h00

// Result width and divider terminal counts (divide by 2, 8, 32)
`define ADCC_RES_W 10
`define ADCC_DIV2_LAST 5'h01
`define ADCC_DIV8_LAST 5'h07
`define ADCC_DIV32_LAST 5'h1F

// Reference pin use per pin function code, one bit per code
`define ADCC_VPOS_MAP 16'hBD2A
`define ADCC_VNEG_MAP 16'hB900

`endif

// >>> core/adcc_pkg.sv
// Types shared by the converter control block
// Assumes: compiled before every other converter control file
package adcc_pkg;

    // Conversion clock choice, in field code order
    typedef enum logic [1:0] {
        ADCC_CLK_DIV2,
        ADCC_CLK_DIV8,
        ADCC_CLK_DIV32,
        ADCC_CLK_RC
    } adcc_clk_sel_t;

    // Successive approximation sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_sar_state_t;

endpackage

// >>> core/adcc_sar.sv
// Successive approximation sequencer: one sample period, then one bit
// per conversion clock tick, most significant bit first
// Assumes: comparator input is synchronous to clk_sys and answers the
// current trial code within the same cycle
module adcc_sar #(
    parameter int RES_W = 10
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic cmp_above,
    output logic busy_q,
    output logic hold_q,
    output logic done_q,
    output logic [RES_W-1:0] trial_q,
    output logic [RES_W-1:0] result_q
);
    localparam int IW = $clog2(RES_W);

    adcc_pkg::adcc_sar_state_t st_q, st_d;
    logic [IW-1:0] idx_q, idx_d;
    logic [RES_W-1:0] trial_d, result_d, acc;
    logic busy_d, hold_d, done_d;

    // Next state; abort wins so a powered-off core never reports
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        trial_d = trial_q;
        result_d = result_q;
        busy_d = busy_q;
        hold_d = hold_q;
        done_d = 1'b0;
        acc = trial_q;
        acc[idx_q] = cmp_above;
        if (abort) begin
            st_d = adcc_pkg::ADCC_IDLE;
            busy_d = 1'b0;
            hold_d = 1'b0;
        end else begin
            unique case (st_q)
                adcc_pkg::ADCC_IDLE: begin
                    if (start) begin
                        st_d = adcc_pkg::ADCC_SAMPLE;
                        busy_d = 1'b1;
                        trial_d = '0;
                    end
                end
                adcc_pkg::ADCC_SAMPLE: begin
                    if (tick) begin
                        st_d = adcc_pkg::ADCC_CONVERT;
                        hold_d = 1'b1;
                        trial_d = '0;
                        trial_d[RES_W-1] = 1'b1;
                        idx_d = IW'(RES_W - 1);
                    end
                end
                adcc_pkg::ADCC_CONVERT: begin
                    // Keep the trial bit only if the input is at or above
                    if (tick) begin
                        trial_d = acc;
                        if (idx_q == '0) begin
                            result_d = acc;
                            done_d = 1'b1;
                            busy_d = 1'b0;
                            hold_d = 1'b0;
                            st_d = adcc_pkg::ADCC_IDLE;
                        end else begin
                            idx_d = idx_q - 1'b1;
                            trial_d[idx_q - 1'b1] = 1'b1;
                        end
                    end
                end
                default: st_d = adcc_pkg::ADCC_IDLE;
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= adcc_pkg::ADCC_IDLE;
            idx_q <= '0;
            trial_q <= '0;
            result_q <= '0;
            busy_q <= 1'b0;
            hold_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            trial_q <= trial_d;
            result_q <= result_d;
            busy_q <= busy_d;
            hold_q <= hold_d;
            done_q <= done_d;
        end
    end

endmodule

// >>> core/adcc_top.sv
// Converter control: registers, conversion clock, sequencing, interrupt
// Assumes: a byte register port on clk_sys, an analog core that takes
// the trial code and returns its comparator decision on clk_sys
`include "adcc_map.svh"

module adcc_top #(
    parameter int NUM_CHANNELS = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata_q,
    output logic irq_q,
    input wire logic sleep_mode,
    input wire logic rc_osc,
    input wire logic cmp_above,
    output logic conv_power_q,
    output logic [2:0] channel_q,
    output logic channel_connected_q,
    output logic hold_q,
    output logic [`ADCC_RES_W-1:0] trial_q,
    output logic [3:0] pin_function_q,
    output logic vref_pos_pin_q,
    output logic vref_neg_pin_q
);
    // Software-visible control state
    adcc_pkg::adcc_clk_sel_t cs_q, cs_d;
    logic [2:0] chs_d;
    logic go_q, go_d, on_d;
    logic just_q, just_d;
    logic [3:0] pfs_d;
    logic chan_ok_d, vpos_d, vneg_d;
    logic [7:0] stat_q, stat_d, mask_q, mask_d;
    logic irq_d;
    logic [7:0] rdata_d;

    // Reference pin maps as vectors, so the pin code can index them
    localparam logic [15:0] VPOS_MAP = `ADCC_VPOS_MAP;
    localparam logic [15:0] VNEG_MAP = `ADCC_VNEG_MAP;

    // Decoded strobes
    logic wr_ctrl, wr_pcfg, wr_stat, wr_mask, start, abort;

    // Conversion clock
    logic [2:0] rc_s_q;
    logic rc_lvl_q, rc_lvl_d, rc_rise;
    logic [4:0] div_cnt_q, div_cnt_d, div_last;
    logic tick_div, tick;

    // Sequencer results
    logic sar_busy, sar_done;
    logic [`ADCC_RES_W-1:0] result;

    assign wr_ctrl = bus_wr && (bus_addr == `ADCC_ADDR_CTRL);
    assign wr_pcfg = bus_wr && (bus_addr == `ADCC_ADDR_PCFG);
    assign wr_stat = bus_wr && (bus_addr == `ADCC_ADDR_ISTAT);
    assign wr_mask = bus_wr && (bus_addr == `ADCC_ADDR_IMASK);

    // Start needs the core already powered; a write that powers up and
    // sets go together would sample before the core has settled
    assign start = wr_ctrl && bus_wdata[`ADCC_GO] && conv_power_q
        && bus_wdata[`ADCC_ON] && !go_q;
    assign abort = !on_d;

    // RC oscillator comes from another domain: three stages, a level
    // change counts once the second and third agree
    always_comb begin
        rc_lvl_d = rc_lvl_q;
        if (rc_s_q[1] == rc_s_q[2]) begin
            rc_lvl_d = rc_s_q[2];
        end
    end
    assign rc_rise = rc_lvl_d && !rc_lvl_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rc_s_q <= '0;
            rc_lvl_q <= 1'b0;
        end else begin
            rc_s_q <= {rc_s_q[1:0], rc_osc};
            rc_lvl_q <= rc_lvl_d;
        end
    end

    // Oscillator divider, free running so the bit period is exact
    always_comb begin
        unique case (cs_q)
            adcc_pkg::ADCC_CLK_DIV2: div_last = `ADCC_DIV2_LAST;
            adcc_pkg::ADCC_CLK_DIV8: div_last = `ADCC_DIV8_LAST;
            adcc_pkg::ADCC_CLK_DIV32: div_last = `ADCC_DIV32_LAST;
            adcc_pkg::ADCC_CLK_RC: div_last = `ADCC_DIV32_LAST;
        endcase
        tick_div = (div_cnt_q >= div_last);
        div_cnt_d = tick_div ? '0 : div_cnt_q + 5'h01;
    end

    // Oscillator-derived ticks stop in sleep; the RC clock keeps going
    assign tick = (cs_q == adcc_pkg::ADCC_CLK_RC) ? rc_rise
        : (tick_div && !sleep_mode);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    adcc_sar #(
        .RES_W(`ADCC_RES_W)
    ) u_sar (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(start),
        .abort(abort),
        .tick(tick),
        .cmp_above(cmp_above),
        .busy_q(sar_busy),
        .hold_q(hold_q),
        .done_q(sar_done),
        .trial_q(trial_q),
        .result_q(result)
    );

    // Control and configuration next values
    always_comb begin
        cs_d = cs_q;
        chs_d = channel_q;
        on_d = conv_power_q;
        just_d = just_q;
        pfs_d = pin_function_q;
        go_d = go_q;
        if (wr_ctrl) begin
            cs_d = adcc_pkg::adcc_clk_sel_t'(
                bus_wdata[`ADCC_CS_HI:`ADCC_CS_LO]);
            chs_d = bus_wdata[`ADCC_CH_HI:`ADCC_CH_LO];
            on_d = bus_wdata[`ADCC_ON];
        end
        if (wr_pcfg) begin
            just_d = bus_wdata[`ADCC_JUST];
            pfs_d = bus_wdata[`ADCC_PF_HI:`ADCC_PF_LO];
        end
        // Go is owned by hardware once set; software clearing it is
        // ignored, only completion or power-down end a conversion
        if (start) begin
            go_d = 1'b1;
        end
        if (sar_done || abort) begin
            go_d = 1'b0;
        end
        chan_ok_d = int'(chs_d) < NUM_CHANNELS;
        vpos_d = VPOS_MAP[pfs_d];
        vneg_d = VNEG_MAP[pfs_d];
    end

    // Interrupt: done event sets, write one clears, the set wins
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_stat) begin
            stat_d = stat_q & ~bus_wdata;
        end
        if (wr_mask) begin
            mask_d = bus_wdata;
        end
        if (sar_done) begin
            stat_d[`ADCC_DONE_BIT] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // Read data stands for the single cycle after the read strobe
    always_comb begin
        rdata_d = '0;
        if (bus_rd) begin
            case (bus_addr)
                `ADCC_ADDR_CTRL: rdata_d = {cs_q, channel_q, go_q, 1'b0,
                    conv_power_q};
                `ADCC_ADDR_PCFG: rdata_d = {just_q, 3'h0, pin_function_q};
                `ADCC_ADDR_RESH: rdata_d = just_q ? {6'h00, result[9:8]}
                    : result[9:2];
                `ADCC_ADDR_RESL: rdata_d = just_q ? result[7:0]
                    : {result[1:0], 6'h00};
                `ADCC_ADDR_ISTAT: rdata_d = stat_q;
                `ADCC_ADDR_IMASK: rdata_d = mask_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // All register state, cleared at power-on except channel_connected_q, which resets to 1
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_q <= adcc_pkg::ADCC_CLK_DIV2;
            channel_q <= '0;
            go_q <= 1'b0;
            conv_power_q <= 1'b0;
            just_q <= 1'b0;
            pin_function_q <= '0;
            channel_connected_q <= 1'b1;
            vref_pos_pin_q <= 1'b0;
            vref_neg_pin_q <= 1'b0;
            stat_q <= `ADCC_IRQ_RST;
            mask_q <= `ADCC_IRQ_RST;
            irq_q <= 1'b0;
            bus_rdata_q <= '0;
        end else begin
            cs_q <= cs_d;
            channel_q <= chs_d;
            go_q <= go_d;
            conv_power_q <= on_d;
            just_q <= just_d;
            pin_function_q <= pfs_d;
            channel_connected_q <= chan_ok_d;
            vref_pos_pin_q <= vpos_d;
            vref_neg_pin_q <= vneg_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            bus_rdata_q <= rdata_d;
        end
    end

    // Ticks seen by the current conversion: one sample plus one per bit
    logic [4:0] conv_ticks_q, conv_ticks_d;

    always_comb begin
        conv_ticks_d = conv_ticks_q;
        if (start) begin
            conv_ticks_d = '0;
        end else if (sar_busy && tick) begin
            conv_ticks_d = conv_ticks_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            conv_ticks_q <= '0;
        end else begin
            conv_ticks_q <= conv_ticks_d;
        end
    end

    // Checks on the control behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    go_start_a: assert property (start |=> go_q && sar_busy)
        else $error("go bit or sequencer not set after start");
    go_clear_a: assert property (sar_done |=> !go_q)
        else $error("go bit still set after completion");
    done_flag_a: assert property (
        sar_done |=> stat_q[`ADCC_DONE_BIT])
        else $error("done flag not raised on completion");
    conv_length_a: assert property (
        sar_done |-> conv_ticks_q == 5'(`ADCC_RES_W + 1))
        else $error("conversion not one sample plus one tick per bit");
    off_start_a: assert property (
        wr_ctrl && bus_wdata[`ADCC_GO] && !conv_power_q
        |=> !go_q && !sar_busy)
        else $error("conversion started while powered off");
    power_off_a: assert property (
        !conv_power_q |-> !go_q && !hold_q)
        else $error("converter active while powered off");
    bit1_zero_a: assert property (
        bus_rd && bus_addr == `ADCC_ADDR_CTRL
        |=> !bus_rdata_q[1] && bus_rdata_q[`ADCC_GO] == $past(go_q))
        else $error("control read shows bad bit 1 or go bit");
    right_pad_a: assert property (
        bus_rd && bus_addr == `ADCC_ADDR_RESH && just_q
        |=> bus_rdata_q[7:2] == 6'h00)
        else $error("right justified high byte not padded");
    left_pad_a: assert property (
        bus_rd && bus_addr == `ADCC_ADDR_RESL && !just_q
        |=> bus_rdata_q[5:0] == 6'h00)
        else $error("left justified low byte not padded");
    sleep_hold_a: assert property (
        sleep_mode && cs_q != adcc_pkg::ADCC_CLK_RC && go_q
        && !wr_ctrl |=> $stable(trial_q))
        else $error("conversion advanced in sleep off the RC clock");
    div8_rate_a: assert property (
        (tick_div && cs_q == adcc_pkg::ADCC_CLK_DIV8
        ##1 (cs_q == adcc_pkg::ADCC_CLK_DIV8 && !tick_div)[*7])
        |=> tick_div || cs_q != adcc_pkg::ADCC_CLK_DIV8)
        else $error("divide by eight tick spacing wrong");
    chan_route_a: assert property (
        wr_ctrl |=> channel_q == $past(bus_wdata[`ADCC_CH_HI:`ADCC_CH_LO])
        && channel_connected_q == (int'(channel_q) < NUM_CHANNELS))
        else $error("channel select not routed");

    done_cov_c: cover property (start ##[1:1000] sar_done);
    rc_cov_c: cover property (
        cs_q == adcc_pkg::ADCC_CLK_RC && sleep_mode && sar_done);
    irq_cov_c: cover property (sar_done ##1 irq_q);

endmodule

// >>> tb/adcc_analog_model.sv
// Behavioural analog core: input mux, sample hold and comparator
// Assumes: bench sets levels[] by name; the RC oscillator runs freely
module adcc_analog_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic conv_power_q,
    input wire logic [2:0] channel_q,
    input wire logic channel_connected_q,
    input wire logic hold_q,
    input wire logic [9:0] trial_q,
    output logic cmp_above,
    output logic rc_osc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] levels [8];
    logic [9:0] held_q;
    logic [9:0] noise_q;

    // RC oscillator, 40 ns, phase unrelated to clk_sys
    initial begin
        for (int i = 0; i < 8; i++) begin
            levels[i] = 10'h000;
        end
        rc_osc = 1'b0;
        #7;
        forever #20 rc_osc = ~rc_osc;
    end

    // Tracks the routed input until hold; open inputs float, so noise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            held_q <= 10'h000;
            noise_q <= 10'h000;
        end else begin
            noise_q <= ~noise_q ^ 10'h155;
            if (!hold_q) begin
                held_q <= channel_connected_q ? levels[channel_q]
                    : noise_q;
            end
        end
    end

    // Unpowered comparator never says above
    assign cmp_above = conv_power_q && (held_q >= trial_q);
endmodule

// >>> tb/adc_conversion_control_test.sv
// Self-checking bench for the converter control, small package build
// Assumes: core/ on the include path, analog model from tb/
module adc_conversion_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, resetn, bus_wr, bus_rd, irq_q, sleep_mode, rc_osc;
    logic [7:0] bus_addr, bus_wdata, bus_rdata_q;
    logic cmp_above, conv_power_q, channel_connected_q, hold_q;
    logic [2:0] channel_q;
    logic [9:0] trial_q;
    logic [3:0] pin_function_q;
    logic vref_pos_pin_q, vref_neg_pin_q, mask_on;
    int errors = 0;
    int samples_checked = 0;

    adcc_top #(.NUM_CHANNELS(5)) i_adcc_top (
        .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata_q(bus_rdata_q), .irq_q(irq_q), .sleep_mode(sleep_mode),
        .rc_osc(rc_osc), .cmp_above(cmp_above), .conv_power_q(conv_power_q),
        .channel_q(channel_q), .channel_connected_q(channel_connected_q),
        .hold_q(hold_q), .trial_q(trial_q), .pin_function_q(pin_function_q),
        .vref_pos_pin_q(vref_pos_pin_q), .vref_neg_pin_q(vref_neg_pin_q));

    adcc_analog_model i_adcc_analog_model (
        .clk_sys(clk_sys), .resetn(resetn), .conv_power_q(conv_power_q),
        .channel_q(channel_q), .channel_connected_q(channel_connected_q),
        .hold_q(hold_q), .trial_q(trial_q), .cmp_above(cmp_above),
        .rc_osc(rc_osc));

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample there
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                         input string nm);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(nm, e, bus_rdata_q);
    endtask

    // Polls go bit, bounded so a stuck sequencer cannot hang the run
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            bus_addr <= 8'h1F;
            bus_rd <= 1'b1;
            @(posedge clk_sys);
            bus_rd <= 1'b0;
            #1;
            n++;
        end while (bus_rdata_q[2] !== 1'b0 && n < 400);
        chk("go cleared", 16'h0000, {15'h0, bus_rdata_q[2]});
    endtask

    task automatic t_reset();
        chk("power out", 16'h0, conv_power_q);
        chk("irq out", 16'h0, irq_q);
        rdchk(8'h1F, 8'h00, "ctrl reset");
        rdchk(8'h9F, 8'h00, "config reset");
        rdchk(8'h1E, 8'h00, "res high reset");
        rdchk(8'h9E, 8'h00, "res low reset");
        rdchk(8'h20, 8'h00, "status reset");
        rdchk(8'h21, 8'h00, "mask reset");
        rdchk(8'h55, 8'h00, "unmapped");
    endtask

    task automatic t_loose();
        wr(8'h1F, 8'h02);
        rdchk(8'h1F, 8'h00, "bit one");
        wr(8'h1F, 8'h04);
        repeat (400) @(posedge clk_sys);
        rdchk(8'h1F, 8'h00, "go unpowered");
        rdchk(8'h20, 8'h00, "flag unpowered");
    endtask

    task automatic t_chan();
        for (int c = 0; c < 8; c++) begin
            wr(8'h1F, {2'b00, c[2:0], 3'b000});
            repeat (2) @(posedge clk_sys);
            #1;
            chk("channel", c, channel_q);
            chk("connected", c < 5, channel_connected_q);
        end
    endtask

    task automatic t_pins();
        logic [15:0] pos, neg;
        pos = 16'hBD2A;
        neg = 16'hB900;
        for (int c = 0; c < 16; c++) begin
            wr(8'h9F, c[7:0]);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("pin function", c, pin_function_q);
            chk("vref pos", pos[c], vref_pos_pin_q);
            chk("vref neg", neg[c], vref_neg_pin_q);
        end
    endtask

    // Full conversion, then result, flag and interrupt handling
    task automatic conv(input logic [1:0] cs, input logic [2:0] ch,
                        input logic [9:0] lv, input logic jr);
        i_adcc_analog_model.levels[ch] = lv;
        wr(8'h9F, {jr, 7'h00});
        wr(8'h1F, {cs, ch, 3'b001});
        repeat (70) @(posedge clk_sys);
        wr(8'h1F, {cs, ch, 3'b101});
        rdchk(8'h1F, {cs, ch, 3'b101}, "go busy");
        wait_idle();
        chk("hold idle", 16'h0, hold_q);
        rdchk(8'h1F, {cs, ch, 3'b001}, "ctrl after");
        chk("irq", mask_on, irq_q);
        rdchk(8'h1E, jr ? {6'h00, lv[9:8]} : lv[9:2], "res high");
        rdchk(8'h9E, jr ? lv[7:0] : {lv[1:0], 6'h00}, "res low");
        wr(8'h21, 8'h01);
        rdchk(8'h20, 8'h01, "done flag");
        chk("irq masked in", 16'h1, irq_q);
        wr(8'h20, 8'h01);
        rdchk(8'h20, 8'h00, "flag cleared");
        chk("irq cleared", 16'h0, irq_q);
        wr(8'h21, {7'h00, mask_on});
    endtask

    task automatic t_abort();
        wr(8'h1F, 8'h81);
        wr(8'h1F, 8'h85);
        repeat (20) @(posedge clk_sys);
        wr(8'h1F, 8'h80);
        repeat (400) @(posedge clk_sys);
        rdchk(8'h1F, 8'h80, "abort ctrl");
        rdchk(8'h20, 8'h00, "abort flag");
        chk("power off", 16'h0, conv_power_q);
    endtask

    // Divided clock freezes in sleep; RC clock keeps converting
    task automatic t_sleep();
        sleep_mode <= 1'b1;
        wr(8'h1F, 8'h49);
        wr(8'h1F, 8'h4D);
        repeat (300) @(posedge clk_sys);
        rdchk(8'h1F, 8'h4D, "frozen go");
        rdchk(8'h20, 8'h00, "frozen flag");
        chk("frozen trial", 16'h0, trial_q);
        chk("frozen hold", 16'h0, hold_q);
        sleep_mode <= 1'b0;
        wait_idle();
        rdchk(8'h20, 8'h01, "thawed flag");
        wr(8'h20, 8'h01);
        sleep_mode <= 1'b1;
        conv(2'b11, 3'd4, 10'h1C3, 1'b1);
        sleep_mode <= 1'b0;
    endtask

    // Watchdog, about eight times the expected run of some 2.5k cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("[ERR] watchdog expected done seen hang");
        results();
    end

    initial begin
        logic [9:0] lv [4];
        lv = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A};
        resetn = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        sleep_mode = 1'b0;
        mask_on = 1'b0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_loose();
        t_chan();
        t_pins();
        for (int i = 0; i < 4; i++) begin
            mask_on = i[0];
            wr(8'h21, {7'h00, mask_on});
            conv(i[1:0], i[2:0], lv[i], i[1]);
        end
        t_abort();
        t_sleep();
        results();
    end
endmodule
